/* File: pkg/image_map_pkg.sv */
// Shared constants and types for the fieldbus slave image mapper and its master end.
package image_map_pkg;
	// ------------------------------------------------------------
	// Address and timing
	// ------------------------------------------------------------
	localparam logic [6:0] DEFAULT_ADDR = 7'h0B;
	localparam int CLK_HZ = 125_000_000;
	localparam int BLINK_STOP_MS = 2000;
	localparam int BLINK_STOP_CYC = CLK_HZ / 1000 * BLINK_STOP_MS;
	localparam int RATE_CNT = 7;
	localparam int RATE_KBPS [RATE_CNT] = '{9600, 19200, 93750, 187500, 500000, 1500000, 12000000};
	// ------------------------------------------------------------
	// Module descriptor fields
	// ------------------------------------------------------------
	localparam int KIND_BIT = 0;
	localparam int MAP_BIT = 1;
	localparam int DIR_LO = 2;
	localparam int CHN_LO = 4;
	localparam int BITS_LO = 8;
	localparam logic [1:0] DIR_IN = 2'h1;
	localparam logic [1:0] DIR_OUT = 2'h2;
	localparam logic [1:0] DIR_BOTH = 2'h3;
	localparam int CHAN_BYTES_CPLX = 3;
	localparam int CHAN_BYTES_CMPT = 2;
	typedef logic [15:0] desc_t;
endpackage : image_map_pkg

/* File: pkg/image_link_if.sv */
// Interface joining the slave and master ends of the image link.
`timescale 1ns/1ns
interface image_link_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	logic dir_out;
	logic [7:0] in_len;
	logic [7:0] out_len;
	logic rate_strobe;
	logic ok;
	modport slave (input data, input valid, output ready, input dir_out, output in_len, output out_len,
		input rate_strobe, output ok);
	modport master (output data, output valid, input ready, output dir_out, input in_len, input out_len,
		output rate_strobe, input ok);
endinterface : image_link_if

/* File: logic/byte_fifo.sv */
// Byte FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_clk, // System clock.
	input wire logic i_arst_n, // Async reset, active low.
	input wire logic [WIDTH-1:0] i_data, // Write data.
	input wire logic i_valid, // Write valid.
	output logic o_ready, // Not full.
	output logic [WIDTH-1:0] o_data, // Read data.
	output logic o_valid, // Not empty.
	input wire logic i_ready // Read accept.
);
	localparam int AW = $clog2(DEPTH);
	// Pointer wrap relies on a power-of-two depth.
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("DEPTH must be a power of two.");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q, rp_q;
	// ------------------------------------------------------------
	// Pointers and storage
	// ------------------------------------------------------------
	assign o_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
	assign o_valid = wp_q != rp_q;
	assign o_data = mem_q[rp_q[AW-1:0]];
	// Storage is flip-flops; the read side stalls the write side when full.
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wp_q <= '0;
			rp_q <= '0;
			for (int k = 0; k < DEPTH; k++) mem_q[k] <= '0;
		end
		else
		begin
			if (i_valid && o_ready)
			begin
				mem_q[wp_q[AW-1:0]] <= i_data;
				wp_q <= wp_q + 1'b1;
			end
			if (o_valid && i_ready) rp_q <= rp_q + 1'b1;
		end
	end
endmodule : byte_fifo

/* File: logic/image_mapper_slave.sv */
// Slave end: start-up, address capture, rate lock and process image layout.
//
// What this block does
// RL1 - Self check, init link, enumerate modules
// RL2 - Start local controller after clean list
// RL3 - Stop indicator flashing about two seconds, once running; it keeps flashing after a start-up error
// RL4 - Address equals tens digit times ten plus units
// RL5 - Unset address defaults to eleven
// RL6 - Switches sampled only at power-on
// RL7 - Detect bit rate once, hold it
// RL8 - No re-detection while powered
// RL9 - One contiguous input and output block
// RL10 - Slots mapped automatically into image
// RL11 - Byte modules first, bit channels after
// RL12 - Master lists byte modules in order
// RL13 - Bit channels packed, padded with zeros
// RL14 - Bit groups of 8, 16 or 32
// RL15 - Byte module entries equal size per channel
// RL16 - Analog in 24/8, out 8/24 entries
// RL17 - Channel count sets per-channel entries
// RL18 - Compact: four sixteen-bit output words
// RL19 - Complex: three bytes per channel each way
// RL20 - Mapping type applies to whole module
// RL21 - Two-byte data optionally byte swapped
// RL22 - Rate detector locks before data exchange
`timescale 1ns/1ns
module image_mapper_slave #(
	parameter int MODS = 8,
	parameter int BLINK_CYC = image_map_pkg::BLINK_STOP_CYC
) (
	input wire logic i_clk, // System clock.
	input wire logic i_arst_n, // Power-on reset, active low.
	input wire logic [3:0] i_tens_digit_switch, // Tens selector.
	input wire logic [3:0] i_units_digit_switch, // Units selector.
	input wire logic [MODS*16-1:0] i_mod_desc, // Module descriptors, slot order.
	input wire logic i_mod_present, // Extension link present.
	input wire logic i_has_ctrl, // Local controller fitted.
	input wire logic i_swap_bytes, // Swap two-byte data.
	image_link_if.slave link, // Link to master.
	output logic [6:0] o_station_addr, // Latched address.
	output logic [2:0] o_rate_idx, // Latched rate.
	output logic o_rate_lock, // Rate found.
	output logic o_ctrl_run, // Controller started.
	output logic o_io_blink, // Indicator flashing.
	output logic o_ready, // Exchange enabled.
	output logic o_err, // Start-up error.
	output logic [7:0] o_in_data, // Received output byte.
	output logic o_in_valid, // Received byte strobe.
	input wire logic i_in_ready // Sink ready.
);
	// The slot index is four bits wide, so at most fifteen slots fit.
	if (MODS < 1 || MODS > 15)
	begin : g_bad_mods
		$error("MODS out of range.");
	end
	typedef enum logic [2:0] {
		ST_CHECK = 3'b000,
		ST_SCAN = 3'b001,
		ST_RATE = 3'b010,
		ST_RUN = 3'b011,
		ST_FAIL = 3'b100
	} state_e;
	typedef struct packed {
		state_e st;
		logic [3:0] s1_t, s2_t, s1_u, s2_u;
		logic [6:0] addr;
		logic addr_ok;
		logic [1:0] settle;
		logic [3:0] slot;
		logic [7:0] byte_in, byte_out;
		logic [7:0] bit_in, bit_out;
		logic [2:0] rate;
		logic lock;
		logic [31:0] blink_cnt;
		logic blink, ctrl, err;
		logic [7:0] in_len, out_len;
		logic rs1, rs2, rs3;
		logic [2:0] edges;
		logic [7:0] hold;
		logic [7:0] rx_byte;
		logic rx_odd, rx_emit;
	} state_s;
	state_s q, d;
	logic f_valid, f_ready;
	logic fifo_pop, swap_on;
	logic [7:0] f_data;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Per-module byte counts for one direction.
	function automatic logic [7:0] entry_bytes(input image_map_pkg::desc_t e, input logic out_dir);
		logic [7:0] ch;
		logic [7:0] n;
		ch = {4'h0, e[image_map_pkg::CHN_LO +: 4]};
		n = 8'h00;
		if (e[image_map_pkg::MAP_BIT])
		begin
			// Complex mapping gives a full entry in each data direction; analog in/out adds a status/control byte.
			if (e[image_map_pkg::DIR_LO +: 2] == image_map_pkg::DIR_BOTH)
				n = 8'(ch * image_map_pkg::CHAN_BYTES_CPLX); // RL19
			else if (e[image_map_pkg::DIR_LO +: 2] == image_map_pkg::DIR_IN)
				n = out_dir ? ch : 8'(ch * image_map_pkg::CHAN_BYTES_CPLX); // RL16
			else
				n = out_dir ? 8'(ch * image_map_pkg::CHAN_BYTES_CPLX) : ch; // RL16
		end
		else if ((e[image_map_pkg::DIR_LO +: 2] == image_map_pkg::DIR_OUT) == out_dir)
			n = 8'(ch * image_map_pkg::CHAN_BYTES_CMPT); // RL15 RL18
		return n;
	endfunction : entry_bytes
	// Whole bytes needed for a bit count, zero-padded.
	function automatic logic [7:0] bits_to_bytes(input logic [7:0] b);
		return 8'((9'(b) + 9'd7) >> 3);
	endfunction : bits_to_bytes
	image_map_pkg::desc_t cur;
	assign cur = i_mod_desc[q.slot*16 +: 16];
	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.s1_t = i_tens_digit_switch;
		d.s2_t = q.s1_t;
		d.s1_u = i_units_digit_switch;
		d.s2_u = q.s1_u;
		d.rs1 = link.rate_strobe;
		d.rs2 = q.rs1;
		d.rs3 = q.rs2;
		if (q.blink && q.blink_cnt < 32'(BLINK_CYC)) d.blink_cnt = q.blink_cnt + 1'b1;
		// Strobe edges count from reset on, so pulses sent while the list is built are not lost.
		if (!q.lock)
		begin
			if (q.rs2 && !q.rs3)
			begin
				if (q.edges != 3'(image_map_pkg::RATE_CNT)) d.edges = q.edges + 1'b1;
				d.hold = 8'hFF;
			end
			else if (q.hold != 8'h00)
				d.hold = q.hold - 1'b1;
		end
		unique case (q.st)
			ST_CHECK:
			begin
				// One capture after reset, once the synchronisers hold pin values rather than reset zeros.
				if (!q.addr_ok)
				begin
					if (q.settle != 2'h2)
						d.settle = q.settle + 1'b1;
					else
					begin
						d.addr_ok = 1'b1; // RL6
						if (q.s2_t > 4'h9 || q.s2_u > 4'h9)
							d.addr = image_map_pkg::DEFAULT_ADDR; // RL5
						else
							d.addr = 7'(q.s2_t) * 7'd10 + 7'(q.s2_u); // RL4
					end
				end
				else if (i_mod_present)
					d.st = ST_SCAN; // RL1
				else
					d.st = ST_RATE;
			end
			ST_SCAN:
			begin
				// Byte modules accumulate in slot order; bit channels are summed and appended.
				if (cur[image_map_pkg::KIND_BIT])
				begin
					d.byte_in = q.byte_in + entry_bytes(cur, 1'b0); // RL10 RL11 RL17 RL20
					d.byte_out = q.byte_out + entry_bytes(cur, 1'b1);
				end
				else
				begin
					if (!(cur[image_map_pkg::BITS_LO +: 8] inside {8'd0, 8'd8, 8'd16, 8'd32})) d.err = 1'b1; // RL14
					if (cur[image_map_pkg::DIR_LO]) d.bit_in = q.bit_in + cur[image_map_pkg::BITS_LO +: 8];
					if (cur[image_map_pkg::DIR_LO+1]) d.bit_out = q.bit_out + cur[image_map_pkg::BITS_LO +: 8];
				end
				d.slot = q.slot + 1'b1;
				if (q.slot == 4'(MODS-1)) d.st = ST_RATE;
			end
			ST_RATE:
			begin
				d.in_len = q.byte_in + bits_to_bytes(q.bit_in); // RL9 RL13
				d.out_len = q.byte_out + bits_to_bytes(q.bit_out);
				d.ctrl = i_has_ctrl && !q.err; // RL2
				if (q.err)
					d.st = ST_FAIL;
				else if (d.hold == 8'h00 && d.edges != 3'h0)
				begin
					// Rate index is the strobe count less one after a quiet window, then frozen.
					d.rate = d.edges - 3'd1;
					d.lock = 1'b1; // RL7 RL22
					d.st = ST_RUN;
				end
			end
			ST_RUN:
			begin
				// Rate stays latched; only power cycling relearns it.
				d.rate = q.rate; // RL8
				// With swapping, the first byte of a pair is parked until its partner has gone out.
				if (q.rx_emit)
				begin
					if (i_in_ready) d.rx_emit = 1'b0;
				end
				else if (swap_on && !q.rx_odd)
				begin
					if (f_valid)
					begin
						d.rx_byte = f_data;
						d.rx_odd = 1'b1;
					end
				end
				else if (swap_on && f_valid && i_in_ready)
				begin
					d.rx_odd = 1'b0;
					d.rx_emit = 1'b1; // RL21
				end
			end
			ST_FAIL: d.st = ST_FAIL;
			default: d.st = ST_FAIL;
		endcase
		if (q.blink_cnt >= 32'(BLINK_CYC) && q.st == ST_RUN) d.blink = 1'b0; // RL3
	end
	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			q <= '0;
			q.st <= ST_CHECK;
			q.blink <= 1'b1;
		end
		else
			q <= d;
	end
	// Received bytes pass the FIFO; the sink can stall the master.
	byte_fifo #(.WIDTH(8), .DEPTH(8)) byte_fifo_i (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_data(link.data),
		.i_valid(link.valid && q.st == ST_RUN),
		.o_ready(f_ready),
		.o_data(f_data),
		.o_valid(f_valid),
		.i_ready(fifo_pop)
	);
	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Two-byte words swap when i_swap_bytes and link.dir_out are both high; the default keeps high byte first.
	// A parked first byte is popped without the sink, so a swap never needs a look-ahead read.
	assign swap_on = i_swap_bytes && link.dir_out;
	assign fifo_pop = q.rx_emit ? 1'b0 : ((swap_on && !q.rx_odd) ? f_valid : (f_valid && i_in_ready));
	assign o_in_data = q.rx_emit ? q.rx_byte : f_data; // RL21
	assign o_in_valid = q.rx_emit || (f_valid && !(swap_on && !q.rx_odd));
	assign link.ready = f_ready && q.st == ST_RUN;
	assign link.in_len = q.in_len;
	assign link.out_len = q.out_len;
	assign link.ok = q.st == ST_RUN;
	assign o_station_addr = q.addr;
	assign o_rate_idx = q.rate;
	assign o_rate_lock = q.lock;
	assign o_ctrl_run = q.ctrl;
	assign o_io_blink = q.blink;
	assign o_ready = q.st == ST_RUN;
	assign o_err = q.st == ST_FAIL;
endmodule : image_mapper_slave

/* File: logic/image_mapper_master.sv */
// Master end: announces the rate and streams output bytes of the contiguous block.
`timescale 1ns/1ns
module image_mapper_master #(
	parameter int RATE_IDX = 0
) (
	input wire logic i_clk, // System clock.
	input wire logic i_arst_n, // Async reset, active low.
	image_link_if.master link, // Link to slave.
	input wire logic [7:0] i_data, // Byte to send.
	input wire logic i_valid, // Byte available.
	output logic o_ready, // Byte taken.
	output logic [7:0] o_in_len, // Slave input block length.
	output logic [7:0] o_out_len, // Slave output block length.
	output logic o_ok // Slave exchanging.
);
	// The pulse counter is three bits, so only the listed rates can be announced.
	if (RATE_IDX < 0 || RATE_IDX >= image_map_pkg::RATE_CNT)
	begin : g_bad_rate
		$error("RATE_IDX out of range.");
	end
	typedef struct packed {
		logic [2:0] pulses;
		logic [1:0] ph;
		logic [7:0] data;
		logic valid;
		logic [7:0] in_len, out_len;
		logic ok;
	} state_s;
	state_s q, d;
	// ------------------------------------------------------------
	// Rate strobe and data path
	// ------------------------------------------------------------
	// Sends RATE_IDX+1 spaced pulses once; the block is one contiguous stream in the caller's order.
	always_comb
	begin
		d = q;
		d.ph = q.ph + 1'b1;
		if (q.ph == 2'h3 && q.pulses != 3'(RATE_IDX + 1)) d.pulses = q.pulses + 1'b1;
		if (link.ready && q.valid) d.valid = 1'b0;
		if (!d.valid && i_valid)
		begin
			d.data = i_data;
			d.valid = 1'b1;
		end
		d.in_len = link.in_len;
		d.out_len = link.out_len;
		d.ok = link.ok;
	end
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n) q <= '0;
		else q <= d;
	end
	assign link.rate_strobe = q.ph == 2'h0 && q.pulses != 3'(RATE_IDX + 1); // RL8
	assign link.data = q.data;
	assign link.valid = q.valid; // RL9
	assign link.dir_out = 1'b1;
	assign o_ready = !q.valid || link.ready;
	assign o_in_len = q.in_len;
	assign o_out_len = q.out_len;
	assign o_ok = q.ok;
endmodule : image_mapper_master

/* File: verification/image_link_props.sv */
// Concurrent checks on the image link between the slave and master ends.
`timescale 1ns/1ns
module image_link_props (
	input wire logic i_clk, // System clock.
	input wire logic i_arst_n, // Async reset, active low.
	input wire logic [7:0] data, // Link byte.
	input wire logic valid, // Byte offered.
	input wire logic ready, // Byte accepted.
	input wire logic dir_out, // Transfer direction.
	input wire logic [7:0] in_len, // Input block length.
	input wire logic [7:0] out_len, // Output block length.
	input wire logic rate_strobe, // Rate pulses.
	input wire logic ok // Slave exchanging.
);
	logic [8:0] quiet_q;
	logic [8:0] quiet_d;
	// Quiet cycles since the last rate pulse; it saturates so a long idle never wraps back to zero.
	always_comb
	begin
		quiet_d = rate_strobe ? 9'h000 : (quiet_q[8] ? quiet_q : quiet_q + 9'h001);
	end
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			quiet_q <= 9'h000;
		else
			quiet_q <= quiet_d;
	end
	// ------------------------------------------------------------
	// Link checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	data_hold_a: assert property (valid && !ready |=> valid && $stable(data))
		else $error("link byte dropped or changed while waiting");
	accept_run_a: assert property (ready |-> ##[0:1] ok)
		else $error("byte accepted while not exchanging");
	in_len_fixed_a: assert property (ok && $past(ok, 2) |-> $stable(in_len))
		else $error("input block length moved while running");
	out_len_fixed_a: assert property (ok && $past(ok, 2) |-> $stable(out_len))
		else $error("output block length moved while running");
	run_holds_a: assert property (ok |=> ok)
		else $error("exchange dropped without a power cycle");
	no_redetect_a: assert property (ok |-> !rate_strobe)
		else $error("rate pulse seen while exchanging");
	strobe_pulse_a: assert property (rate_strobe |=> !rate_strobe)
		else $error("rate pulse longer than one cycle");
	quiet_first_a: assert property ($rose(ok) |-> quiet_q >= 9'h0FE)
		else $error("exchange began before the rate settled");
	// The covers show that start-up, transfer and stall all happened.
	cover property ($rose(ok));
	cover property (valid && ready);
	cover property (valid && !ready && ok);
endmodule : image_link_props

/* File: verification/fieldbus_slave_image_mapper_test.sv */
// Testbench joining the slave and master ends through the image link.
`timescale 1ns/1ns
module fieldbus_slave_image_mapper_test;
	// Slot 0 sits in the low word: bit in 8, complex both 4ch, bit out 16, compact out 4ch.
	localparam logic [63:0] GOOD = 64'h0049_1008_004F_0804;
	// Complex in 2ch, complex out 1ch, compact in 2ch, empty slot.
	localparam logic [63:0] MIXED = 64'h0000_0025_001B_0027;
	// Each entry holds tens, units and the expected address.
	localparam logic [15:0] ATAB [4] = '{16'h9963, 16'h110B, 16'hA20B, 16'h0000};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] tens = 4'h0;
	logic [3:0] units = 4'h0;
	logic [63:0] desc = 64'h0000_0000_0000_0000;
	logic swap = 1'b0;
	logic has_ctrl = 1'b0;
	logic present = 1'b1;
	logic [7:0] m_data = 8'h00;
	logic m_valid = 1'b0;
	logic in_ready = 1'b0;
	logic m_ready, ok, lock, run, blink, s_ready, s_err, in_valid;
	logic [7:0] in_data, in_len, out_len;
	logic [6:0] addr;
	logic [2:0] rate;
	logic [7:0] exq[$];
	int n_fail = 0;
	int checks_done = 0;
	image_link_if link ();
	// ------------------------------------------------------------
	// Both ends and the checker
	// ------------------------------------------------------------
	image_mapper_slave #(.MODS(4), .BLINK_CYC(100)) image_mapper_slave_i (.i_clk(clk), .i_arst_n(rst_n),
		.i_tens_digit_switch(tens), .i_units_digit_switch(units), .i_mod_desc(desc), .i_mod_present(present),
		.i_has_ctrl(has_ctrl), .i_swap_bytes(swap), .link(link), .o_station_addr(addr), .o_rate_idx(rate),
		.o_rate_lock(lock), .o_ctrl_run(run), .o_io_blink(blink), .o_ready(s_ready), .o_err(s_err),
		.o_in_data(in_data), .o_in_valid(in_valid), .i_in_ready(in_ready));
	image_mapper_master #(.RATE_IDX(4)) image_mapper_master_i (.i_clk(clk), .i_arst_n(rst_n), .link(link),
		.i_data(m_data), .i_valid(m_valid), .o_ready(m_ready), .o_in_len(in_len), .o_out_len(out_len), .o_ok(ok));
	image_link_props image_link_props_i (.i_clk(clk), .i_arst_n(rst_n), .data(link.data), .valid(link.valid),
		.ready(link.ready), .dir_out(link.dir_out), .in_len(link.in_len), .out_len(link.out_len),
		.rate_strobe(link.rate_strobe), .ok(link.ok));
	// Free-running clock at 125 MHz.
	initial
	begin
		forever #4 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h, expected %h", $time, seen, want);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	// A power cycle: switches and modules are set while reset holds, since they are read only at start-up.
	task automatic power_up(input logic [3:0] t, input logic [3:0] u, input logic [63:0] d, input logic sw,
		input logic hc);
		int k;
		@(posedge clk);
		rst_n <= 1'b0;
		tens <= t;
		units <= u;
		desc <= d;
		swap <= sw;
		has_ctrl <= hc;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (k = 0; k < 3000 && s_ready !== 1'b1 && s_err !== 1'b1; k++)
			@(negedge clk);
		// The master's copy of the run flag trails the slave by one cycle.
		repeat (2) @(negedge clk);
		check(8'(k < 3000), 8'h01);
	endtask : power_up
	// Offers a byte and holds it until taken or the limit runs out; valid stays up either way.
	task automatic push(input logic [7:0] b, input int lim, output bit got);
		m_data <= b;
		m_valid <= 1'b1;
		got = 1'b0;
		for (int k = 0; k < lim && !got; k++)
		begin
			@(negedge clk);
			got = (m_ready === 1'b1);
			@(posedge clk);
		end
	endtask : push
	// Pops every queued expectation with the sink ready throughout.
	task automatic drain();
		in_ready <= 1'b1;
		for (int k = 0; k < 500 && exq.size() > 0; k++)
		begin
			@(negedge clk);
			if (in_valid === 1'b1)
				check(in_data, exq.pop_front());
			@(posedge clk);
		end
		in_ready <= 1'b0;
		check(8'(exq.size()), 8'h00);
	endtask : drain
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		bit got;
		int n;
		power_up(4'h3, 4'h4, GOOD, 1'b0, 1'b1);
		check(8'(addr), 8'h22);
		check(8'(rate), 8'h04);
		check(8'(lock), 8'h01);
		check(8'(ok), 8'h01);
		check(8'(run), 8'h01);
		check(in_len, 8'h0D);
		check(out_len, 8'h16);
		@(posedge clk);
		tens <= 4'h7;
		repeat (120) @(negedge clk);
		check(8'(blink), 8'h00);
		check(8'(addr), 8'h22);
		check(8'(rate), 8'h04);
		$display("test start-up done");
		@(posedge clk);
		n = 0;
		got = 1'b1;
		while (got && n < 40)
		begin
			push(8'(n), 20, got);
			if (got)
				n++;
		end
		check(8'(n >= 8), 8'h01);
		for (int i = 0; i <= n; i++)
			exq.push_back(8'(i));
		fork
			begin
				push(8'(n), 200, got);
				m_valid <= 1'b0;
			end
			drain();
		join
		@(negedge clk);
		check(8'(in_valid), 8'h00);
		$display("test buffer done");
		foreach (ATAB[i])
		begin
			power_up(ATAB[i][15:12], ATAB[i][11:8], GOOD, 1'b0, 1'b1);
			check(8'(addr), ATAB[i][7:0]);
		end
		$display("test address done");
		power_up(4'h1, 4'h2, 64'h0049_1008_004F_0C04, 1'b0, 1'b1);
		check(8'(s_err), 8'h01);
		check(8'(s_ready), 8'h00);
		check(8'(run), 8'h00);
		check(8'(ok), 8'h00);
		check(8'(blink), 8'h01);
		$display("test error done");
		power_up(4'h0, 4'h5, MIXED, 1'b0, 1'b0);
		check(in_len, 8'h0B);
		check(out_len, 8'h05);
		@(posedge clk);
		present <= 1'b0;
		power_up(4'h0, 4'h5, GOOD, 1'b0, 1'b0);
		check(in_len, 8'h00);
		check(8'(addr), 8'h05);
		@(posedge clk);
		present <= 1'b1;
		$display("test layout done");
		power_up(4'h1, 4'h2, GOOD, 1'b1, 1'b0);
		check(8'(run), 8'h00);
		@(posedge clk);
		push(8'hA1, 50, got);
		push(8'hB2, 50, got);
		m_valid <= 1'b0;
		exq = '{8'hB2, 8'hA1};
		drain();
		$display("test swap done");
		stop_test();
	end
	// Watchdog sized well above the few thousand cycles the tests need.
	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		stop_test();
	end
endmodule : fieldbus_slave_image_mapper_test
